// >>> pkg/ufc_defs.svh
// Purpose: constants for the flow-controlled serial transceiver pair
// Assumes: 40 MHz clk_sys, bytes moved by a simple memory master port
// Notes:   included by the package and the design modules
//
// Summary of operation
// - two independent transceiver channels are built side by side.
// - the bit period is programmable, with 1 Mbps as the fastest allowed rate.
// - each channel drives a request-to-send output toward the partner.
// - flow control on the clear-to-send line can be switched on or off; request-to-send is always driven.
// - request-to-send goes off whenever the receiver cannot take data, power saving included.
// - a frame is a start bit, 8 data bits, an optional even parity bit and one stop bit.
// - after reset the frame is eight data bits, no parity, one stop bit.
// - data bits go out and come in least significant bit first.
// - bytes move to and from memory by the block's own memory master, one byte per access.
// - each serial signal may be routed to any pin not already claimed.
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

`define UFC_CLK_HZ        40000000
`define UFC_BAUD_MAX_BPS  1000000
`define UFC_DIV_MIN       (`UFC_CLK_HZ / `UFC_BAUD_MAX_BPS)
`define UFC_DIV_W         16
`define UFC_DIV_RST       16'h015b
`define UFC_PAR_RST       1'b0
`define UFC_FLOW_RST      1'b0
`define UFC_BITS_8N1      4'ha
`define UFC_BITS_8E1      4'hb
`define UFC_CHAN_N        2
`define UFC_SIG_N         4
`define UFC_SIG_TXD       0
`define UFC_SIG_RTS       1
`define UFC_SIG_RXD       2
`define UFC_SIG_CTS       3
`define UFC_PIN_W         5
`define UFC_ERR_PAR       0
`define UFC_ERR_FRM       1
`define UFC_ERR_OVR       2

`endif

// >>> pkg/ufc_pkg.sv
// Purpose: shared types of the serial transceiver pair
// Assumes: ufc_defs.svh on the include path
// Notes:   widths come from the constants header
`include "ufc_defs.svh"

package ufc_pkg;
    typedef struct packed {
        logic [`UFC_DIV_W-1:0] div;
        logic                  par_en;
        logic                  flow_en;
    } ufc_cfg_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } ufc_mreq_s;

    typedef struct packed {
        logic                  en;
        logic [`UFC_PIN_W-1:0] pin;
    } ufc_route_s;

    typedef enum logic [2:0] {TX_IDLE, TX_FETCH, TX_WAIT, TX_HOLD, TX_SHIFT} ufc_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufc_rx_e;
endpackage

// >>> rtl/ufc_baud.sv
// Purpose: bit-period tick generator, restartable at full or half period
// Assumes: div at least 2
// Notes:   tick is a one-cycle enable, never a clock
`timescale 1ns/1ps
`include "ufc_defs.svh"

module ufc_baud #(
    parameter int W = `UFC_DIV_W
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         restart,
    input  wire logic         half,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    always_comb begin
        next_tick = 1'b0;
        if (restart) begin
            next_cnt = half ? (div >> 1) : div - 1'b1;
        end else if (cnt == '0) begin
            next_cnt  = div - 1'b1;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// >>> rtl/ufc_top.sv
// Purpose: serial transceiver channel with memory master, and the two-channel top with pin routing
// Assumes: pins and memory answers synchronous to clk_sys
// Notes:   ufc_top is the top module; ufc_chan is one channel
`timescale 1ns/1ps
`include "ufc_defs.svh"

module ufc_chan (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             cfg_wr,
    input  ufc_pkg::ufc_cfg_s     cfg_in,
    input  wire logic             power_save,
    input  wire logic             tx_go,
    input  wire logic [31:0]      tx_ptr,
    input  wire logic [15:0]      tx_len,
    input  wire logic             rx_go,
    input  wire logic [31:0]      rx_ptr,
    input  wire logic [15:0]      rx_max,
    input  wire logic             mem_gnt,
    input  wire logic             mem_rvalid,
    input  wire logic [7:0]       mem_rdata,
    input  wire logic             rxd,
    input  wire logic             cts_n,
    output ufc_pkg::ufc_mreq_s    mem_o,
    output logic                  txd,
    output logic                  rts_n,
    output logic                  tx_busy,
    output logic                  tx_done,
    output logic [15:0]           rx_count,
    output logic [2:0]            rx_err
);
    ufc_pkg::ufc_cfg_s  cfg, next_cfg;
    logic               cfg_seen, next_cfg_seen;
    ufc_pkg::ufc_tx_e   tx_st, next_tx_st;
    logic [31:0]        tx_addr, next_tx_addr;
    logic [15:0]        tx_left, next_tx_left;
    logic [7:0]         tx_byte, next_tx_byte;
    logic [10:0]        tx_sh, next_tx_sh;
    logic [3:0]         tx_bits, next_tx_bits;
    logic               tx_par, next_tx_par;
    logic               next_txd, next_tx_done, next_tx_busy, tx_restart, tx_tick;
    ufc_pkg::ufc_rx_e   rx_st, next_rx_st;
    logic [7:0]         rx_sh, next_rx_sh, hold_byte, next_hold_byte;
    logic [2:0]         rx_cnt, next_rx_cnt, next_rx_err;
    logic               rx_perr, next_rx_perr, hold_full, next_hold_full;
    logic [31:0]        rx_addr, next_rx_addr;
    logic [15:0]        next_rx_count;
    logic               rx_armed, next_rx_armed, next_rts_n, rx_restart, rx_tick;
    ufc_pkg::ufc_mreq_s next_mem;
    logic               wr_done;

    ufc_baud u_tx_baud (.clk_sys(clk_sys), .resetn(resetn), .restart(tx_restart),
                        .half(1'b0), .div(cfg.div), .tick(tx_tick));
    ufc_baud u_rx_baud (.clk_sys(clk_sys), .resetn(resetn), .restart(rx_restart),
                        .half(1'b1), .div(cfg.div), .tick(rx_tick));

    // configuration, rate clamped to the fastest legal setting
    always_comb begin
        next_cfg      = cfg;
        next_cfg_seen = cfg_seen;
        if (cfg_wr) begin
            next_cfg      = cfg_in;
            next_cfg_seen = 1'b1;
            if (cfg_in.div < 16'(`UFC_DIV_MIN))
                next_cfg.div = 16'(`UFC_DIV_MIN);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg.div     <= `UFC_DIV_RST;
            cfg.par_en  <= `UFC_PAR_RST;
            cfg.flow_en <= `UFC_FLOW_RST;
            cfg_seen    <= 1'b0;
        end else begin
            cfg      <= next_cfg;
            cfg_seen <= next_cfg_seen;
        end
    end

    // memory master: receive writes take priority over transmit reads
    assign wr_done = mem_o.req && mem_o.we && mem_gnt;

    always_comb begin
        next_mem = mem_o;
        if (mem_o.req) begin
            if (mem_gnt)
                next_mem.req = 1'b0;
        end else if (hold_full) begin
            next_mem = '{req: 1'b1, we: 1'b1, addr: rx_addr, wdata: hold_byte};
        end else if (tx_st == ufc_pkg::TX_FETCH) begin
            next_mem = '{req: 1'b1, we: 1'b0, addr: tx_addr, wdata: 8'h00};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            mem_o <= '0;
        else
            mem_o <= next_mem;
    end

    // transmitter
    always_comb begin
        next_tx_st   = tx_st;
        next_tx_addr = tx_addr;
        next_tx_left = tx_left;
        next_tx_byte = tx_byte;
        next_tx_sh   = tx_sh;
        next_tx_bits = tx_bits;
        next_tx_par  = tx_par;
        next_txd     = txd;
        next_tx_done = 1'b0;
        tx_restart   = 1'b0;
        unique case (tx_st)
            ufc_pkg::TX_IDLE: begin
                if (tx_go && tx_len != 16'h0000) begin
                    next_tx_addr = tx_ptr;
                    next_tx_left = tx_len;
                    next_tx_st   = ufc_pkg::TX_FETCH;
                end
            end
            ufc_pkg::TX_FETCH: begin
                if (mem_o.req && !mem_o.we && mem_gnt)
                    next_tx_st = ufc_pkg::TX_WAIT;
            end
            ufc_pkg::TX_WAIT: begin
                if (mem_rvalid) begin
                    next_tx_byte = mem_rdata;
                    next_tx_st   = ufc_pkg::TX_HOLD;
                end
            end
            ufc_pkg::TX_HOLD: begin
                if (!cfg.flow_en || !cts_n) begin
                    next_tx_par  = cfg.par_en;
                    next_tx_sh   = cfg.par_en ? {1'b1, ^tx_byte, tx_byte, 1'b0}
                                              : {2'b11, tx_byte, 1'b0};
                    next_tx_bits = (cfg.par_en ? `UFC_BITS_8E1 : `UFC_BITS_8N1) - 4'h1;
                    next_txd     = 1'b0;
                    tx_restart   = 1'b1;
                    next_tx_st   = ufc_pkg::TX_SHIFT;
                end
            end
            ufc_pkg::TX_SHIFT: begin
                if (tx_tick) begin
                    next_tx_sh = {1'b1, tx_sh[10:1]};
                    next_txd   = tx_sh[1];
                    if (tx_bits == 4'h0) begin
                        next_tx_addr = tx_addr + 32'h1;
                        next_tx_left = tx_left - 16'h1;
                        if (tx_left == 16'h1) begin
                            next_tx_st   = ufc_pkg::TX_IDLE;
                            next_tx_done = 1'b1;
                        end else begin
                            next_tx_st = ufc_pkg::TX_FETCH;
                        end
                    end else begin
                        next_tx_bits = tx_bits - 4'h1;
                    end
                end
            end
            default: next_tx_st = ufc_pkg::TX_IDLE;
        endcase
        next_tx_busy = (next_tx_st != ufc_pkg::TX_IDLE);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_st   <= ufc_pkg::TX_IDLE;
            tx_addr <= '0;
            tx_left <= '0;
            tx_byte <= '0;
            tx_sh   <= '1;
            tx_bits <= '0;
            tx_par  <= 1'b0;
            txd     <= 1'b1;
            tx_done <= 1'b0;
            tx_busy <= 1'b0;
        end else begin
            tx_st   <= next_tx_st;
            tx_addr <= next_tx_addr;
            tx_left <= next_tx_left;
            tx_byte <= next_tx_byte;
            tx_sh   <= next_tx_sh;
            tx_bits <= next_tx_bits;
            tx_par  <= next_tx_par;
            txd     <= next_txd;
            tx_done <= next_tx_done;
            tx_busy <= next_tx_busy;
        end
    end

    // receiver, one-byte holding stage drained to memory
    always_comb begin
        next_rx_st     = rx_st;
        next_rx_sh     = rx_sh;
        next_rx_cnt    = rx_cnt;
        next_rx_perr   = rx_perr;
        next_hold_byte = hold_byte;
        next_hold_full = hold_full;
        next_rx_addr   = rx_addr;
        next_rx_count  = rx_count;
        next_rx_armed  = rx_armed;
        next_rx_err    = rx_err;
        rx_restart     = 1'b0;
        if (rx_go) begin
            next_rx_addr  = rx_ptr;
            next_rx_count = 16'h0000;
            next_rx_armed = (rx_max != 16'h0000);
            next_rx_err   = 3'h0;
        end
        if (wr_done) begin
            next_hold_full = 1'b0;
            next_rx_addr   = rx_addr + 32'h1;
            next_rx_count  = rx_count + 16'h1;
            if (rx_count + 16'h1 == rx_max)
                next_rx_armed = 1'b0;
        end
        unique case (rx_st)
            ufc_pkg::RX_IDLE: begin
                if (!rxd) begin
                    rx_restart = 1'b1;
                    next_rx_st = ufc_pkg::RX_START;
                end
            end
            ufc_pkg::RX_START: begin
                if (rx_tick) begin
                    next_rx_cnt  = 3'h0;
                    next_rx_perr = 1'b0;
                    next_rx_st   = rxd ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA;
                end
            end
            ufc_pkg::RX_DATA: begin
                if (rx_tick) begin
                    next_rx_sh  = {rxd, rx_sh[7:1]};
                    next_rx_cnt = rx_cnt + 3'h1;
                    if (rx_cnt == 3'h7)
                        next_rx_st = cfg.par_en ? ufc_pkg::RX_PAR : ufc_pkg::RX_STOP;
                end
            end
            ufc_pkg::RX_PAR: begin
                if (rx_tick) begin
                    next_rx_perr = rxd ^ (^rx_sh);
                    next_rx_st   = ufc_pkg::RX_STOP;
                end
            end
            ufc_pkg::RX_STOP: begin
                if (rx_tick) begin
                    next_rx_st = ufc_pkg::RX_IDLE;
                    if (!rxd)
                        next_rx_err[`UFC_ERR_FRM] = 1'b1;
                    if (cfg.par_en && rx_perr)
                        next_rx_err[`UFC_ERR_PAR] = 1'b1;
                    if (next_rx_armed && !next_hold_full) begin
                        next_hold_byte = rx_sh;
                        next_hold_full = 1'b1;
                    end else begin
                        next_rx_err[`UFC_ERR_OVR] = 1'b1;
                    end
                end
            end
            default: next_rx_st = ufc_pkg::RX_IDLE;
        endcase
        next_rts_n = !(next_rx_armed && !next_hold_full && !power_save);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_st     <= ufc_pkg::RX_IDLE;
            rx_sh     <= '0;
            rx_cnt    <= '0;
            rx_perr   <= 1'b0;
            hold_byte <= '0;
            hold_full <= 1'b0;
            rx_addr   <= '0;
            rx_count  <= '0;
            rx_armed  <= 1'b0;
            rx_err    <= '0;
            rts_n     <= 1'b1;
        end else begin
            rx_st     <= next_rx_st;
            rx_sh     <= next_rx_sh;
            rx_cnt    <= next_rx_cnt;
            rx_perr   <= next_rx_perr;
            hold_byte <= next_hold_byte;
            hold_full <= next_hold_full;
            rx_addr   <= next_rx_addr;
            rx_count  <= next_rx_count;
            rx_armed  <= next_rx_armed;
            rx_err    <= next_rx_err;
            rts_n     <= next_rts_n;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_rts_power_off: assert property (power_save |=> rts_n)
        else $error("rts not off during power saving");
    a_cts_stall_hold: assert property (
        cfg.flow_en && cts_n && tx_st == ufc_pkg::TX_HOLD |=> tx_st == ufc_pkg::TX_HOLD)
        else $error("frame started while clear-to-send off");
    a_no_flow_start: assert property (
        !cfg.flow_en && tx_st == ufc_pkg::TX_HOLD |=> tx_st == ufc_pkg::TX_SHIFT && !txd)
        else $error("frame held without flow control");
    a_tx_start_bit: assert property (
        tx_st == ufc_pkg::TX_SHIFT && $past(tx_st) == ufc_pkg::TX_HOLD |-> !txd)
        else $error("start bit not low");
    a_tx_lsb_first: assert property (
        tx_st == ufc_pkg::TX_SHIFT && tx_bits == (tx_par ? 4'h9 : 4'h8) |-> txd == tx_byte[0])
        else $error("first data bit is not the lsb");
    a_tx_even_par: assert property (
        tx_st == ufc_pkg::TX_SHIFT && tx_par && tx_bits == 4'h1 |-> txd == ^tx_byte)
        else $error("parity bit not even");
    a_tx_stop_bit: assert property (
        tx_st == ufc_pkg::TX_SHIFT && tx_bits == 4'h0 |-> txd)
        else $error("stop bit not high");
    a_reset_8n1: assert property (!cfg_seen |-> !cfg.par_en && !cfg.flow_en)
        else $error("frame format after reset not 8N1");
    a_baud_floor: assert property (cfg.div >= 16'(`UFC_DIV_MIN))
        else $error("bit period faster than 1 Mbps");
    a_dma_count: assert property (
        wr_done && !rx_go |=> rx_count == $past(rx_count) + 16'h1)
        else $error("memory write not counted");

    c_tx_frame: cover property (tx_done);
    c_rx_store: cover property (wr_done);
    c_cts_stall: cover property (cfg.flow_en && cts_n && tx_st == ufc_pkg::TX_HOLD);
endmodule

module ufc_top #(
    parameter int PIN_N = 8
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic [1:0]             cfg_wr,
    input  ufc_pkg::ufc_cfg_s [1:0]     cfg_in,
    input  wire logic [1:0]             power_save,
    input  wire logic [1:0]             tx_go,
    input  wire logic [1:0][31:0]       tx_ptr,
    input  wire logic [1:0][15:0]       tx_len,
    input  wire logic [1:0]             rx_go,
    input  wire logic [1:0][31:0]       rx_ptr,
    input  wire logic [1:0][15:0]       rx_max,
    input  wire logic [1:0]             mem_gnt,
    input  wire logic [1:0]             mem_rvalid,
    input  wire logic [1:0][7:0]        mem_rdata,
    input  ufc_pkg::ufc_route_s [7:0]   route,
    input  wire logic [PIN_N-1:0]       pin_claim,
    input  wire logic [PIN_N-1:0]       pin_in,
    output ufc_pkg::ufc_mreq_s [1:0]    mem_o,
    output logic [1:0]                  tx_busy,
    output logic [1:0]                  tx_done,
    output logic [1:0][15:0]            rx_count,
    output logic [1:0][2:0]             rx_err,
    output logic [PIN_N-1:0]            pin_out,
    output logic [PIN_N-1:0]            pin_oe
);
    wire  [1:0]       txd, rts_n, rxd, cts_n;
    logic [PIN_N-1:0] next_pin_out, next_pin_oe;

    function automatic logic hit(input ufc_pkg::ufc_route_s r, input int p,
                                 input logic [PIN_N-1:0] claim);
        hit = r.en && (r.pin == `UFC_PIN_W'(p)) && !claim[p];
    endfunction

    // pins and claims as arguments so that every pin change re-evaluates the caller
    function automatic logic pick(input ufc_pkg::ufc_route_s r, input logic idle,
                                  input logic [PIN_N-1:0] pins, input logic [PIN_N-1:0] claim);
        pick = idle;
        for (int p = 0; p < PIN_N; p++)
            if (hit(r, p, claim))
                pick = pins[p];
    endfunction

    for (genvar ch = 0; ch < `UFC_CHAN_N; ch++) begin : g_chan
        ufc_chan u_chan (
            .clk_sys(clk_sys), .resetn(resetn), .cfg_wr(cfg_wr[ch]), .cfg_in(cfg_in[ch]),
            .power_save(power_save[ch]), .tx_go(tx_go[ch]), .tx_ptr(tx_ptr[ch]),
            .tx_len(tx_len[ch]), .rx_go(rx_go[ch]), .rx_ptr(rx_ptr[ch]), .rx_max(rx_max[ch]),
            .mem_gnt(mem_gnt[ch]), .mem_rvalid(mem_rvalid[ch]), .mem_rdata(mem_rdata[ch]),
            .rxd(rxd[ch]), .cts_n(cts_n[ch]), .mem_o(mem_o[ch]), .txd(txd[ch]),
            .rts_n(rts_n[ch]), .tx_busy(tx_busy[ch]), .tx_done(tx_done[ch]),
            .rx_count(rx_count[ch]), .rx_err(rx_err[ch]));
        // unrouted receive idles high, unrouted clear-to-send reads as on
        assign rxd[ch]   = pick(route[ch*`UFC_SIG_N+`UFC_SIG_RXD], 1'b1,
                                pin_in, pin_claim);
        assign cts_n[ch] = pick(route[ch*`UFC_SIG_N+`UFC_SIG_CTS], 1'b0,
                                pin_in, pin_claim);
    end

    // first matching output signal owns a free pin
    always_comb begin
        next_pin_out = '0;
        next_pin_oe  = '0;
        for (int p = 0; p < PIN_N; p++) begin
            for (int ch = 0; ch < `UFC_CHAN_N; ch++) begin
                if (!next_pin_oe[p] &&
                    hit(route[ch*`UFC_SIG_N+`UFC_SIG_TXD], p, pin_claim)) begin
                    next_pin_out[p] = txd[ch];
                    next_pin_oe[p]  = 1'b1;
                end
                if (!next_pin_oe[p] &&
                    hit(route[ch*`UFC_SIG_N+`UFC_SIG_RTS], p, pin_claim)) begin
                    next_pin_out[p] = rts_n[ch];
                    next_pin_oe[p]  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end
endmodule

// >>> verif/ufc_peer.sv
// Purpose: serial partner on channel 0 pins, sends and receives frames
// Assumes: bit period and parity set by the bench before use
// Notes:   lines idle high as with a pull-up
`timescale 1ns/1ps

module ufc_peer (
    input  wire logic clk_sys,
    input  wire logic txd,
    input  wire logic rts_n,
    output logic      rxd,
    output logic      cts_n
);
    int         div    = 347;
    logic       par    = 1'b0;
    logic [7:0] got    = 8'h00;
    logic       frm_ok = 1'b0;
    int         frames = 0;

    initial begin
        rxd   = 1'b1;
        cts_n = 1'b0;
    end

    // hold off while the device is not ready
    task automatic send(input logic [7:0] b, input logic bad);
        logic [9:0] f;
        f = {(par ? (^b ^ bad) : 1'b1), b, 1'b0};
        while (rts_n) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (div) @(posedge clk_sys);
        end
        rxd <= 1'b1;
        repeat (par ? div : 1) @(posedge clk_sys);
    endtask

    always begin
        logic p;
        @(negedge txd);
        repeat (div / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk_sys);
            got[i] = txd;
        end
        p = ^got;
        if (par) begin
            repeat (div) @(posedge clk_sys);
            p = txd;
        end
        repeat (div) @(posedge clk_sys);
        frm_ok = txd && (p == ^got);
        frames++;
    end
endmodule

// >>> verif/ufc_top_tb.sv
// Purpose: self-checking bench of the two-channel serial transceiver
// Assumes: channel c signal s routed to pin c*4+s; channel 1 looped back
// Notes:   memory grants at once, read data is the address byte xor 5a
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end

module ufc_top_tb;
    logic                           clk_sys = 1'b0, resetn = 1'b0;
    logic [1:0]                     cfg_wr = '0, power_save = '0, tx_go = '0, rx_go = '0;
    ufc_pkg::ufc_cfg_s [1:0]        cfg_in = '0;
    logic [1:0][31:0]               tx_ptr = '0, rx_ptr = '0, wr_addr;
    logic [1:0][15:0]               tx_len = '0, rx_max = '0, rx_count;
    logic [1:0]                     mem_gnt, mem_rvalid = '0, tx_busy, tx_done;
    logic [1:0][7:0]                mem_rdata = '0, wr_data;
    ufc_pkg::ufc_route_s [7:0]      route;
    logic [7:0]                     pin_claim = '0, pin_in, pin_out, pin_oe, line;
    ufc_pkg::ufc_mreq_s [1:0]       mem_o;
    logic [1:0][2:0]                rx_err;
    logic                           p_rxd, p_cts_n;
    int                             mismatches = 0, compares = 0, cyc = 0, n;

    initial forever #12.5 clk_sys = ~clk_sys;
    initial for (int i = 0; i < 8; i++) route[i] = '{en: 1'b1, pin: 5'(i)};
    assign line    = pin_out | ~pin_oe;
    assign pin_in  = {1'b0, line[4], 2'h3, p_cts_n, p_rxd, 2'h3};
    assign mem_gnt = {mem_o[1].req, mem_o[0].req};

    ufc_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
        .power_save(power_save), .tx_go(tx_go), .tx_ptr(tx_ptr), .tx_len(tx_len),
        .rx_go(rx_go), .rx_ptr(rx_ptr), .rx_max(rx_max), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .route(route),
        .pin_claim(pin_claim), .pin_in(pin_in), .mem_o(mem_o), .tx_busy(tx_busy),
        .tx_done(tx_done), .rx_count(rx_count), .rx_err(rx_err), .pin_out(pin_out),
        .pin_oe(pin_oe));
    ufc_peer u_peer (.clk_sys(clk_sys), .txd(line[0]), .rts_n(line[1]), .rxd(p_rxd),
        .cts_n(p_cts_n));

    always @(posedge clk_sys) begin
        for (int c = 0; c < 2; c++) begin
            mem_rvalid[c] <= mem_o[c].req && !mem_o[c].we;
            mem_rdata[c]  <= mem_o[c].addr[7:0] ^ 8'h5a;
            if (mem_o[c].req && mem_o[c].we) begin
                wr_data[c] <= mem_o[c].wdata;
                wr_addr[c] <= mem_o[c].addr;
            end
        end
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic cfg(input int c, input int d, input logic p, input logic f);
        cfg_in[c] <= '{div: 16'(d), par_en: p, flow_en: f};
        cfg_wr[c] <= 1'b1;
        @(posedge clk_sys);
        cfg_wr[c] <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic arm(input int c, input logic [31:0] p, input logic [15:0] m);
        rx_ptr[c] <= p;
        rx_max[c] <= m;
        rx_go[c]  <= 1'b1;
        @(posedge clk_sys);
        rx_go[c]  <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic tx(input int c, input logic [15:0] len, input logic wait_end);
        tx_ptr[c] <= 32'h1b1;
        tx_len[c] <= len;
        tx_go[c]  <= 1'b1;
        @(posedge clk_sys);
        tx_go[c]  <= 1'b0;
        for (int i = 0; i < 20000 && wait_end && tx_done[c] !== 1'b1; i++) @(posedge clk_sys);
        repeat (400) @(posedge clk_sys);
    endtask

    task automatic wait_cnt(input int c, input logic [15:0] v);
        for (int i = 0; i < 2000 && rx_count[c] !== v; i++) @(posedge clk_sys);
    endtask

    task automatic t_default_tx;
        `CHK("rts_unarmed", 1'b1, pin_out[1])
        tx(0, 16'h0001, 1'b1);
        `CHK("tx_byte", 8'heb, u_peer.got)
        `CHK("tx_frame", 1'b1, u_peer.frm_ok)
        `CHK("tx_busy", 1'b0, tx_busy[0])
        $display("t_default_tx done");
    endtask

    task automatic t_parity;
        cfg(0, 40, 1'b1, 1'b0);
        u_peer.div = 40;
        u_peer.par = 1'b1;
        arm(0, 32'h200, 16'h0004);
        `CHK("rts_armed", 1'b0, pin_out[1])
        u_peer.send(8'h35, 1'b0);
        wait_cnt(0, 16'h0001);
        `CHK("rx_byte", 8'h35, wr_data[0])
        `CHK("rx_err_ok", 3'h0, rx_err[0])
        u_peer.send(8'h35, 1'b1);
        wait_cnt(0, 16'h0002);
        `CHK("rx_addr", 32'h201, wr_addr[0])
        `CHK("rx_par_err", 1'b1, rx_err[0][0])
        n = u_peer.frames;
        tx(0, 16'h0001, 1'b1);
        `CHK("tx_par_count", n + 1, u_peer.frames)
        `CHK("tx_par_frame", 1'b1, u_peer.frm_ok)
        $display("t_parity done");
    endtask

    task automatic t_flow;
        cfg(0, 40, 1'b0, 1'b1);
        u_peer.par = 1'b0;
        u_peer.cts_n <= 1'b1;
        n = u_peer.frames;
        tx(0, 16'h0001, 1'b0);
        `CHK("held_frames", n, u_peer.frames)
        `CHK("held_busy", 1'b1, tx_busy[0])
        u_peer.cts_n <= 1'b0;
        for (int i = 0; i < 2000 && tx_done[0] !== 1'b1; i++) @(posedge clk_sys);
        repeat (100) @(posedge clk_sys);
        `CHK("resumed", n + 1, u_peer.frames)
        `CHK("resumed_byte", 8'heb, u_peer.got)
        $display("t_flow done");
    endtask

    task automatic t_rts;
        power_save[0] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK("rts_save", 1'b1, pin_out[1])
        power_save[0] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK("rts_back", 1'b0, pin_out[1])
        pin_claim[1]  <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK("claimed_oe", 1'b0, pin_oe[1])
        pin_claim[1]  <= 1'b0;
        arm(0, 32'h210, 16'h0001);
        u_peer.send(8'h6c, 1'b0);
        wait_cnt(0, 16'h0001);
        repeat (4) @(posedge clk_sys);
        `CHK("rts_full", 1'b1, pin_out[1])
        $display("t_rts done");
    endtask

    task automatic t_chan1;
        cfg(1, 40, 1'b1, 1'b0);
        arm(1, 32'h300, 16'h0002);
        tx(1, 16'h0003, 1'b1);
        wait_cnt(1, 16'h0002);
        `CHK("ch1_count", 16'h0002, rx_count[1])
        `CHK("ch1_data", 8'he8, wr_data[1])
        `CHK("ch1_addr", 32'h301, wr_addr[1])
        `CHK("ch1_err", 3'h4, rx_err[1])
        $display("t_chan1 done");
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_default_tx();
        t_parity();
        t_flow();
        t_rts();
        t_chan1();
        stop_test();
    end
endmodule
